// ==== irq_unit_pkg.sv ====
// constants, register map and carrier types of the interrupt unit
package irq_unit_pkg;

   // ****************************************
   // register map
   // ****************************************
   localparam logic [7:0] BASIC_MASK_ADDR  = 8'ha8;
   localparam logic [7:0] SOFT_FLAG_ADDR   = 8'had;
   localparam logic [7:0] PRIO_BASIC_ADDR  = 8'hb8;
   localparam logic [7:0] BASIC_MASK_RST   = 8'h00;
   localparam logic [3:0] SOFT_FLAG_RST    = 4'h0;
   localparam logic [5:0] PRIO_BASIC_RST   = 6'h00;
   localparam int         GLOBAL_EN_BIT    = 7;
   localparam int         SOFT_FLAG_LSB    = 4;

   // ****************************************
   // vectors and orders
   // ****************************************
   localparam int          NUM_ORD         = 22;
   localparam logic [15:0] RESET_VECTOR    = 16'h0000;
   localparam logic [15:0] VEC_BASE        = 16'h0003;
   localparam int          VEC_STEP_SHIFT  = 3;
   localparam logic [4:0]  ORD_PIN0        = 5'h00;
   localparam logic [4:0]  ORD_PIN1        = 5'h02;
   localparam logic [4:0]  ORD_UNUSED      = 5'h14;
   localparam int          EXT_PRIO_LSB    = 6;

   // ****************************************
   // pending flags from the peripherals
   // ****************************************
   typedef struct packed {
      logic tmr0OverflowFlag;
      logic tmr1OverflowFlag;
      logic tmr2OverflowFlag;
      logic tmr2ExternalFlag;
      logic uartRxDone;
      logic uartTxDone;
      logic spiXferDone;
      logic spiWriteCollision;
      logic spiModeFault;
      logic spiRxOverrun;
      logic convWindowFlag;
      logic convDoneFlag;
      logic cmpAFallFlag;
      logic cmpARiseFlag;
      logic cmpBFallFlag;
      logic cmpBRiseFlag;
      logic xtalValidFlag;
   } periph_flags_s;

   // register access port
   typedef struct packed {
      logic [7:0] addr;
      logic       wrEn;
      logic [7:0] wrData;
   } sfr_req_s;

   // cpu sequencer events
   typedef struct packed {
      logic ack;
      logic return_from_irq_instr;
      logic instrDone;
      logic flashBusy;
   } cpu_evt_s;

endpackage

// ==== two_level_vectored_interrupt_unit.sv ====
// vectored two-level interrupt controller with fixed order arbitration
//
// Notes on behaviour
// - pin a interrupt vectors to 0x0003, order 0, own enable
// - pin b interrupt vectors to 0x0013, order 2, own enable
// - timer 0 overflow to 0x000B, timer 1 overflow to 0x001B
// - timer 2 overflow or external event to 0x002B, order 5
// - uart rx or tx done to 0x0023, order 4, one enable
// - four spi flags ORed to 0x0033, order 6, one enable
// - converter window flag to 0x0043, order 8, first ext mask
// - comparator a fall 0x0053 order 10, rise 0x005B order 11
// - comparator b fall 0x0063 order 12, rise 0x006B order 13
// - conversion done to 0x007B, order 15, second ext mask
// - four soft flags to 0x0083..0x009B, orders 16 to 19
// - vector 0x00A3, order 20, never requested
// - crystal valid to 0x00AB, order 21, top bit second mask
// - per source level bit; high preempts low, nothing preempts high
// - the six basic priority bits reset to low; ext priority bits are inputs and are not reset
// - higher level first, then lowest fixed order
// - requests sampled and decoded every cycle, one cycle detect
// - after return one more instruction runs before next call
// - worst case eighteen cycles with nothing equal or higher busy
// - no service while flash write or erase stalls the cpu
// - request waits for equal or higher routine, return, one instr
// - basic mask bits 0..5: pin a, tmr0, pin b, tmr1, uart, tmr2
// - software set pending flag requests like hardware
// - edge pin flag cleared on vectoring, level pin flag follows pin
// - soft flags cleared only by software
`timescale 1ns/1ps
module two_level_vectored_interrupt_unit
   import irq_unit_pkg::*;
(
   input  wire logic          core_clk,
   input  wire logic          rst_n,
   input  wire sfr_req_s      sfrReq,
   output      logic [7:0]    sfrRdData_r,
   input  wire logic [7:0]    extMaskRegOne,
   input  wire logic [7:0]    extMaskRegTwo,
   input  wire logic [15:0]   extPrio,
   input  wire periph_flags_s periphFlags,
   input  wire logic          extIrqPinA_n,
   input  wire logic          extIrqPinB_n,
   input  wire logic [1:0]    pinEdgeMode,
   input  wire logic [1:0]    pinPendSet,
   input  wire logic [1:0]    pinPendClr,
   input  wire cpu_evt_s      cpuEvt,
   output      logic          irqReq_r,
   output      logic [15:0]   irqVec_r,
   output      logic [1:0]    pinPending_r
);

   // ****************************************
   // helpers
   // ****************************************
   function automatic logic [4:0] firstSet(input logic [NUM_ORD-1:0] v);
      logic [4:0] idx;
      idx = 5'h00;
      for (int i = NUM_ORD - 1; i >= 0; i--) begin
         if (v[i]) begin
            idx = 5'(i);
         end
      end
      return idx;
   endfunction

   function automatic logic [15:0] vecOf(input logic [4:0] ord);
      return VEC_BASE + (16'(ord) << VEC_STEP_SHIFT);
   endfunction

   // ****************************************
   // registers
   // ****************************************
   logic [7:0] basicMask_r;
   logic [3:0] softFlag_r;
   logic [5:0] prioBasic_r;
   logic [4:0] winOrd_r;
   logic       reqHigh_r;
   logic       inSvcLow_r;
   logic       inSvcHigh_r;
   logic       holdoff_r;

   logic       wrMask;
   logic       wrSoft;
   logic       wrPrio;
   assign wrMask = sfrReq.wrEn && sfrReq.addr == BASIC_MASK_ADDR;
   assign wrSoft = sfrReq.wrEn && sfrReq.addr == SOFT_FLAG_ADDR;
   assign wrPrio = sfrReq.wrEn && sfrReq.addr == PRIO_BASIC_ADDR;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         basicMask_r <= BASIC_MASK_RST;
      end else if (wrMask) begin
         basicMask_r <= sfrReq.wrData;
      end
   end

   // soft flags change only by a write; hardware never clears them
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         softFlag_r <= SOFT_FLAG_RST;
      end else if (wrSoft) begin
         softFlag_r <= sfrReq.wrData[7:SOFT_FLAG_LSB];
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         prioBasic_r <= PRIO_BASIC_RST;
      end else if (wrPrio) begin
         prioBasic_r <= sfrReq.wrData[5:0];
      end
   end

   // unused bits read zero, unmapped addresses read zero
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sfrRdData_r <= 8'h00;
      end else begin
         unique case (sfrReq.addr)
            BASIC_MASK_ADDR: sfrRdData_r <= basicMask_r & 8'hbf;
            SOFT_FLAG_ADDR:  sfrRdData_r <= {softFlag_r, 4'h0};
            PRIO_BASIC_ADDR: sfrRdData_r <= {2'h0, prioBasic_r};
            default:         sfrRdData_r <= 8'h00;
         endcase
      end
   end

   // ****************************************
   // external pins
   // ****************************************
   // three stages; a change counts only once the last two agree
   logic [1:0] pinS1_r;
   logic [1:0] pinS2_r;
   logic [1:0] pinS3_r;
   logic [1:0] pinFilt_r;
   logic [1:0] pinFall;
   logic [1:0] pinAck;
   logic       ackTaken;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pinS1_r <= 2'h3;
         pinS2_r <= 2'h3;
         pinS3_r <= 2'h3;
      end else begin
         pinS1_r <= {extIrqPinB_n, extIrqPinA_n};
         pinS2_r <= pinS1_r;
         pinS3_r <= pinS2_r;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pinFilt_r <= 2'h3;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (pinS2_r[i] == pinS3_r[i]) begin
               pinFilt_r[i] <= pinS3_r[i];
            end
         end
      end
   end

   assign pinFall  = pinFilt_r & ~pinS3_r & ~(pinS2_r ^ pinS3_r);
   assign ackTaken = cpuEvt.ack && irqReq_r;
   assign pinAck[0] = ackTaken && winOrd_r == ORD_PIN0;
   assign pinAck[1] = ackTaken && winOrd_r == ORD_PIN1;

   // edge mode: set wins over any clear in the same cycle
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pinPending_r <= 2'h0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (!pinEdgeMode[i]) begin
               pinPending_r[i] <= ~pinFilt_r[i] | pinPendSet[i];
            end else if (pinFall[i] || pinPendSet[i]) begin
               pinPending_r[i] <= 1'b1;
            end else if (pinAck[i] || pinPendClr[i]) begin
               pinPending_r[i] <= 1'b0;
            end
         end
      end
   end
   // a level source left asserted past its routine simply requests again

   // ****************************************
   // request gathering
   // ****************************************
   logic [NUM_ORD-1:0] flagVec;
   logic [NUM_ORD-1:0] enVec;
   logic [NUM_ORD-1:0] prioVec;
   logic [NUM_ORD-1:0] reqVec;
   logic               globalEn;

   assign globalEn = basicMask_r[GLOBAL_EN_BIT];

   always_comb begin
      flagVec     = '0;
      flagVec[0]  = pinPending_r[0];
      flagVec[1]  = periphFlags.tmr0OverflowFlag;
      flagVec[2]  = pinPending_r[1];
      flagVec[3]  = periphFlags.tmr1OverflowFlag;
      flagVec[4]  = periphFlags.uartRxDone | periphFlags.uartTxDone;
      flagVec[5]  = periphFlags.tmr2OverflowFlag
                  | periphFlags.tmr2ExternalFlag;
      flagVec[6]  = periphFlags.spiXferDone | periphFlags.spiWriteCollision
                  | periphFlags.spiModeFault
                  | periphFlags.spiRxOverrun;
      flagVec[8]  = periphFlags.convWindowFlag;
      flagVec[10] = periphFlags.cmpAFallFlag;
      flagVec[11] = periphFlags.cmpARiseFlag;
      flagVec[12] = periphFlags.cmpBFallFlag;
      flagVec[13] = periphFlags.cmpBRiseFlag;
      flagVec[15] = periphFlags.convDoneFlag;
      flagVec[19:16] = softFlag_r;
      flagVec[21] = periphFlags.xtalValidFlag;
   end

   // order 20 has no flag and no enable, so it can never win
   always_comb begin
      enVec          = '0;
      enVec[5:0]     = basicMask_r[5:0];
      enVec[6]       = extMaskRegOne[0];
      enVec[8]       = extMaskRegOne[2];
      enVec[13:10]   = extMaskRegOne[7:4];
      enVec[15]      = extMaskRegTwo[1];
      enVec[19:16]   = extMaskRegTwo[5:2];
      enVec[21]      = extMaskRegTwo[7];
   end

   assign prioVec = {extPrio, prioBasic_r};
   assign reqVec  = globalEn ? (flagVec & enVec) : '0;

   // ****************************************
   // arbitration
   // ****************************************
   logic       anyHigh;
   logic       anyLow;
   logic [4:0] winHi;
   logic [4:0] winLo;
   logic       eligible;

   assign anyHigh = |(reqVec & prioVec);
   assign anyLow  = |(reqVec & ~prioVec);
   assign winHi   = firstSet(reqVec & prioVec);
   assign winLo   = firstSet(reqVec & ~prioVec);

   // ack cycle is masked so a taken request is not offered twice
   assign eligible = !cpuEvt.flashBusy && !holdoff_r && !inSvcHigh_r
                   && !ackTaken && !cpuEvt.return_from_irq_instr
                   && (anyHigh || (anyLow && !inSvcLow_r));

   // decoded every cycle, presented one cycle later
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         irqReq_r  <= 1'b0;
         irqVec_r  <= RESET_VECTOR;
         winOrd_r  <= 5'h00;
         reqHigh_r <= 1'b0;
      end else begin
         irqReq_r <= eligible;
         if (eligible) begin
            winOrd_r  <= anyHigh ? winHi : winLo;
            irqVec_r  <= vecOf(anyHigh ? winHi : winLo);
            reqHigh_r <= anyHigh;
         end
      end
   end

   // ****************************************
   // service tracking
   // ****************************************
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         inSvcLow_r  <= 1'b0;
         inSvcHigh_r <= 1'b0;
      end else if (ackTaken) begin
         if (reqHigh_r) begin
            inSvcHigh_r <= 1'b1;
         end else begin
            inSvcLow_r <= 1'b1;
         end
      end else if (cpuEvt.return_from_irq_instr) begin
         if (inSvcHigh_r) begin
            inSvcHigh_r <= 1'b0;
         end else begin
            inSvcLow_r <= 1'b0;
         end
      end
   end

   // the instruction that ends with the return itself does not count
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         holdoff_r <= 1'b0;
      end else if (cpuEvt.return_from_irq_instr) begin
         holdoff_r <= 1'b1;
      end else if (cpuEvt.instrDone) begin
         holdoff_r <= 1'b0;
      end
   end
   // worst case latency is set by the cpu: detect, return, divide, call

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   property p_pinA_vec;
      eligible && anyLow && !anyHigh && winLo == ORD_PIN0
         |=> irqReq_r && irqVec_r == 16'h0003;
   endproperty
   a_pinA_vec: assert property (p_pinA_vec)
      else $error("pin a vector wrong");
   // winner must be a high requester with no lower order high requester
   property p_hi_first;
      eligible && anyHigh |=> reqHigh_r
         && (($past(reqVec & prioVec) >> winOrd_r) & 22'h1) == 22'h1
         && ($past(reqVec & prioVec) & ~({NUM_ORD{1'b1}} << winOrd_r)) == '0;
   endproperty
   a_hi_first: assert property (p_hi_first)
      else $error("high level not served first");
   property p_no_unused;
      irqReq_r |-> irqVec_r != 16'h00a3;
   endproperty
   a_no_unused: assert property (p_no_unused)
      else $error("unused vector requested");
   property p_flash;
      cpuEvt.flashBusy |=> !irqReq_r;
   endproperty
   a_flash: assert property (p_flash)
      else $error("request during flash stall");
   property p_global;
      !globalEn && !wrMask |=> !eligible ##1 !irqReq_r;
   endproperty
   a_global: assert property (p_global)
      else $error("request with global enable off");
   property p_no_preempt_hi;
      inSvcHigh_r |=> !irqReq_r;
   endproperty
   a_no_preempt_hi: assert property (p_no_preempt_hi)
      else $error("high routine preempted");
   property p_return_from_irq_instr_hold;
      cpuEvt.return_from_irq_instr ##1 !cpuEvt.instrDone |=> !irqReq_r [*2];
   endproperty
   a_return_from_irq_instr_hold: assert property (p_return_from_irq_instr_hold)
      else $error("call before instruction after return");
   property p_soft_keep;
      !wrSoft |=> softFlag_r == $past(softFlag_r);
   endproperty
   a_soft_keep: assert property (p_soft_keep)
      else $error("soft flag changed without write");
   property p_prio_reset;
      $rose(rst_n) |-> prioBasic_r == 6'h00;
   endproperty
   a_prio_reset: assert property (p_prio_reset)
      else $error("priority not low after reset");
   property p_edge_clear;
      pinEdgeMode[0] && pinAck[0] && !pinFall[0] && !pinPendSet[0]
         |=> !pinPending_r[0];
   endproperty
   a_edge_clear: assert property (p_edge_clear)
      else $error("edge pending not cleared on vectoring");

endmodule

// ==== cpu_seq_model.sv ====
// cpu sequencer model driving the event port of the interrupt unit
`timescale 1ns/1ps
module cpu_seq_model
   import irq_unit_pkg::*;
(
   input  wire logic     core_clk,
   input  wire logic     irqReq_r,
   output      cpu_evt_s cpuEvt
);
   // ****************************************
   // event pulses
   // ****************************************
   initial cpuEvt = '0;
   // k: 3 call, 2 return, 1 instruction done; one cycle each
   task automatic pulse(input int k);
      // a call is refused by the unit unless requested, so never sent
      if (k != 3 || irqReq_r === 1'b1) begin
         cpuEvt[k] = 1'b1;
         @(posedge core_clk);
         #1 cpuEvt[k] = 1'b0;
      end
   endtask
   // flash write or erase stalls the core
   task automatic setFlash(input logic v);
      cpuEvt.flashBusy = v;
   endtask
endmodule

// ==== tb_two_level_vectored_interrupt_unit.sv ====
// self-checking bench of the two level interrupt unit
`timescale 1ns/1ps
module tb_two_level_vectored_interrupt_unit
   import irq_unit_pkg::*;
;
   // ****************************************
   // signals
   // ****************************************
   logic          core_clk = 1'b0;
   logic          rst_n    = 1'b0;
   sfr_req_s      sfrReq   = '0;
   logic [7:0]    sfrRdData_r;
   logic [7:0]    mOne     = 8'h00;
   logic [7:0]    mTwo     = 8'h00;
   logic [15:0]   extPrio  = 16'h0000;
   periph_flags_s pf       = '0;
   logic          pinA_n   = 1'b1;
   logic          pinB_n   = 1'b1;
   logic [1:0]    edgeMode = 2'h0;
   logic [1:0]    pSet     = 2'h0;
   logic [1:0]    pClr     = 2'h0;
   cpu_evt_s      cpuEvt;
   logic          irqReq_r;
   logic [15:0]   irqVec_r;
   logic [1:0]    pinPending_r;
   int            failures = 0;
   int            compares = 0;
   // flag bit 16-k for entry k; enables packed {basic, ext one, ext two}
   localparam logic [15:0] VEC [17] = '{16'h000b, 16'h001b, 16'h002b,
      16'h002b, 16'h0023, 16'h0023, 16'h0033, 16'h0033, 16'h0033,
      16'h0033, 16'h0043, 16'h007b, 16'h0053, 16'h005b, 16'h0063,
      16'h006b, 16'h00ab};
   localparam logic [23:0] EN [17] = '{24'h020000, 24'h080000,
      24'h200000, 24'h200000, 24'h100000, 24'h100000, 24'h000100,
      24'h000100, 24'h000100, 24'h000100, 24'h000400, 24'h000002,
      24'h001000, 24'h002000, 24'h004000, 24'h008000, 24'h000080};

   always #2.5 core_clk = ~core_clk;

   two_level_vectored_interrupt_unit DUT (
      .core_clk     (core_clk),
      .rst_n        (rst_n),
      .sfrReq       (sfrReq),
      .sfrRdData_r  (sfrRdData_r),
      .extMaskRegOne(mOne),
      .extMaskRegTwo(mTwo),
      .extPrio      (extPrio),
      .periphFlags  (pf),
      .extIrqPinA_n (pinA_n),
      .extIrqPinB_n (pinB_n),
      .pinEdgeMode  (edgeMode),
      .pinPendSet   (pSet),
      .pinPendClr   (pClr),
      .cpuEvt       (cpuEvt),
      .irqReq_r     (irqReq_r),
      .irqVec_r     (irqVec_r),
      .pinPending_r (pinPending_r)
   );

   cpu_seq_model cpu (
      .core_clk(core_clk),
      .irqReq_r(irqReq_r),
      .cpuEvt  (cpuEvt)
   );

   // ****************************************
   // tasks
   // ****************************************
   task automatic final_report;
      if (failures == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      compares++;
      if (s !== e) begin
         failures++;
         $display("MISMATCH %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   // strobe lowered then one idle edge, so back to back calls stay clean
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      sfrReq = '{a, 1'b1, d};
      tick(1);
      sfrReq.wrEn = 1'b0;
      tick(1);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      sfrReq.addr = a;
      tick(1);
      chk(16'(sfrRdData_r), 16'(e));
   endtask
   task automatic waitReq(input logic [15:0] v);
      int i;
      for (i = 0; i < 12 && irqReq_r !== 1'b1; i++) tick(1);
      if (i == 12) begin
         failures++;
         $display("MISMATCH %0t request wait ran out", $time);
         final_report;
      end else begin
         chk(irqVec_r, v);
      end
   endtask
   task automatic noReq(input int n);
      repeat (n) begin
         tick(1);
         chk(16'(irqReq_r), 16'h0000);
      end
   endtask
   task automatic ackReq;
      cpu.pulse(3);
      tick(1);
      chk(16'(irqReq_r), 16'h0000);
   endtask
   // return, then exactly one more instruction
   task automatic done;
      cpu.pulse(2);
      tick(1);
      cpu.pulse(1);
      tick(1);
   endtask

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      tick(5);
      chk(irqVec_r, RESET_VECTOR);
      rst_n = 1'b1;
      tick(1);
      rd(PRIO_BASIC_ADDR, 8'h00);
      rd(BASIC_MASK_ADDR, 8'h00);
      wr(BASIC_MASK_ADDR, 8'hff);
      rd(BASIC_MASK_ADDR, 8'hbf);
      wr(PRIO_BASIC_ADDR, 8'hff);
      rd(PRIO_BASIC_ADDR, 8'h3f);
      rd(8'h55, 8'h00);
      wr(PRIO_BASIC_ADDR, 8'h00);
      mTwo = 8'h40;
      noReq(3);
      // every peripheral flag, first with global enable off
      for (int k = 0; k < 17; k++) begin
         mOne = EN[k][15:8];
         mTwo = EN[k][7:0];
         wr(BASIC_MASK_ADDR, EN[k][23:16]);
         pf = periph_flags_s'(17'h1 << (16 - k));
         noReq(3);
         wr(BASIC_MASK_ADDR, EN[k][23:16] | 8'h80);
         waitReq(VEC[k]);
         chk(irqVec_r, VEC[k]);
         ackReq;
         pf = '0;
         done;
      end
      mOne = 8'h00;
      for (int k = 0; k < 4; k++) begin
         mTwo = 8'h04 << k;
         wr(SOFT_FLAG_ADDR, 8'h10 << k);
         waitReq(16'h0083 + 16'(k * 8));
         ackReq;
         rd(SOFT_FLAG_ADDR, 8'h10 << k);
         wr(SOFT_FLAG_ADDR, 8'h00);
         done;
      end
      mTwo = 8'h00;
      edgeMode = 2'b01;
      wr(BASIC_MASK_ADDR, 8'h85);
      pinA_n = 1'b0;
      waitReq(16'h0003);
      ackReq;
      pinA_n = 1'b1;
      tick(2);
      chk(16'(pinPending_r), 16'h0000);
      done;
      pinB_n = 1'b0;
      waitReq(16'h0013);
      ackReq;
      pinB_n = 1'b1; // level source lets go before its return
      tick(5);
      chk(16'(pinPending_r), 16'h0000);
      done;
      pSet = 2'b01;
      tick(1);
      pSet = 2'b00;
      waitReq(16'h0003);
      ackReq;
      done;
      // pin b edge flag: set wins over clear, then clear alone
      wr(BASIC_MASK_ADDR, 8'h05);
      edgeMode = 2'b11;
      pSet = 2'b10;
      pClr = 2'b10;
      tick(1);
      chk(16'(pinPending_r), 16'h0002);
      pSet = 2'b00;
      tick(1);
      chk(16'(pinPending_r), 16'h0000);
      pClr = 2'b00;
      noReq(2);
      // uart high beats tmr0 low, then nesting and holdoff
      wr(BASIC_MASK_ADDR, 8'h92);
      wr(PRIO_BASIC_ADDR, 8'h10);
      pf.tmr0OverflowFlag = 1'b1;
      pf.uartRxDone = 1'b1;
      waitReq(16'h0023);
      ackReq;
      pf.uartRxDone = 1'b0;
      noReq(4);
      done;
      waitReq(16'h000b);
      ackReq;
      pf.uartTxDone = 1'b1;
      waitReq(16'h0023);
      ackReq;
      pf.uartTxDone = 1'b0;
      done;
      noReq(3);
      cpu.pulse(2);
      noReq(2);
      cpu.pulse(1);
      tick(1);
      chk(16'(irqReq_r), 16'h0001);
      waitReq(16'h000b);
      ackReq;
      pf = '0;
      done;
      wr(PRIO_BASIC_ADDR, 8'h00);
      // ext level bit lifts spi above the lower order timer 0
      mOne = 8'h01;
      extPrio = 16'h0001;
      wr(BASIC_MASK_ADDR, 8'h82);
      pf.tmr0OverflowFlag = 1'b1;
      pf.spiXferDone = 1'b1;
      waitReq(16'h0033);
      ackReq;
      pf.spiXferDone = 1'b0;
      done;
      waitReq(16'h000b);
      ackReq;
      pf = '0;
      done;
      mOne = 8'h00;
      extPrio = 16'h0000;
      wr(BASIC_MASK_ADDR, 8'h88);
      cpu.setFlash(1'b1);
      pf.tmr1OverflowFlag = 1'b1;
      noReq(5);
      cpu.setFlash(1'b0);
      waitReq(16'h001b);
      rst_n = 1'b0;
      #1;
      chk(irqVec_r, RESET_VECTOR);
      chk(16'(irqReq_r), 16'h0000);
      tick(2);
      rst_n = 1'b1;
      tick(1);
      rd(BASIC_MASK_ADDR, 8'h00);
      final_report;
   end
endmodule
